//--- inc/vpc_pkg.sv
// Package with constants and carrier types for the voice playback control block
// How it works
// - Reset low forces standby, stops oscillator, grounds audio, latches the straps, clears other state.
// - Busy output is low during playback and high after power-on.
// - Oscillator type select high picks ceramic, low picks RC oscillation.
// - In standby pin two drives low; with RC, pin three drives high.
// - Falling edge of random input fetches random phrase address and plays.
// - During random playback the lowest phrase select bit is ignored.
// - Phrase trigger change waits 16 ms, latches address, then starts playback.
// - Host mode select low means standalone, high means microcontroller mode.
// - Internal busy low during playback except standby transition, and in the half-supply hold with sleep control high.
// - Standby indicator stays low while the oscillator runs.
// - Read strobe driven only while read select is low, floated otherwise.
// - 23-bit ROM address driven while read select low, floated otherwise.
// - ROM data sampled while read select low, forced low otherwise.
// - Sleep control low: standby 0.2 s after voice; high: hold half supply.
package vpc_pkg;
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned CAPTURE_MS      = 16;
  localparam int unsigned SLEEP_MS        = 200;
  localparam int unsigned CAPTURE_CYC     = CLK_HZ / 1000 * CAPTURE_MS;
  localparam int unsigned SLEEP_CYC       = CLK_HZ / 1000 * SLEEP_MS;
  localparam int unsigned ROM_AW          = 23;
  localparam int unsigned ROM_DW          = 8;
  localparam int unsigned WAKE_CYC        = 16;
  localparam int unsigned READ_CYC        = 4;
  localparam logic [15:0] LFSR_SEED       = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS       = 16'hB400;

  // Audio output level selection
  typedef enum logic [1:0] {AUD_GND, AUD_HALF, AUD_PLAY} vpc_aud_t;

  // External ROM pin group
  typedef struct packed {
    logic [ROM_AW-1:0] addr;
    logic              addr_oe;
    logic              strobe_n;
    logic              strobe_oe;
  } vpc_rom_t;

  // Oscillator pin group
  typedef struct packed {
    logic pin_two;
    logic pin_three;
    logic pin_three_oe;
    logic run;
  } vpc_osc_t;
endpackage : vpc_pkg

//--- rtl/vpc_rom_port.sv
// External ROM read port with read-select gating
`timescale 1ns/1ps
module vpc_rom_port
  import vpc_pkg::*;
#(
  parameter int unsigned AW = 23,
  parameter int unsigned DW = 8
) (
  input  wire logic          core_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          rd_req_i,
  input  wire logic [AW-1:0] rd_addr_i,
  input  wire logic          rom_read_select_n_i,
  input  wire logic [DW-1:0] rom_data_bus_i,
  output logic               rd_done_o,
  output logic [DW-1:0]      rd_data_o,
  output vpc_pkg::vpc_rom_t  rom_o
);
  import vpc_pkg::*;

  logic [2:0]    cnt_r;
  logic          act_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] data_r;
  logic          done_r;

  // Read sequencer: strobe low for READ_CYC cycles, sample at end
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      act_r  <= 1'b0;
      cnt_r  <= 3'h0;
      addr_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!act_r && rd_req_i) begin
        act_r  <= 1'b1;
        cnt_r  <= 3'h0;
        addr_r <= rd_addr_i;
      end else if (act_r) begin
        if (cnt_r == 3'(READ_CYC - 1)) begin
          act_r  <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 3'h1;
        end
      end
    end
  end

  // Data capture; pull-downs give zero when deselected
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      data_r <= '0;
    end else if (act_r && cnt_r == 3'(READ_CYC - 1)) begin
      data_r <= rom_read_select_n_i ? '0 : rom_data_bus_i;
    end
  end

  // Pin drive gated by read select
  always_comb begin
    rom_o.addr      = addr_r;
    rom_o.addr_oe   = !rom_read_select_n_i;
    rom_o.strobe_n  = !act_r;
    rom_o.strobe_oe = !rom_read_select_n_i;
  end

  assign rd_done_o = done_r;
  assign rd_data_o = data_r;
endmodule // vpc_rom_port

//--- rtl/vpc_play_ctrl.sv
// Playback control: reset, standby, straps, phrase triggers, random play, ROM fetch
`timescale 1ns/1ps
module vpc_play_ctrl
  import vpc_pkg::*;
#(
  parameter int unsigned CAPTURE_CYCLES = CAPTURE_CYC,
  parameter int unsigned SLEEP_CYCLES   = SLEEP_CYC
) (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              reset_n_i,
  input  wire logic              osc_type_select_i,
  input  wire logic              host_mode_select_i,
  input  wire logic              random_play_n_i,
  input  wire logic [3:0]        phrase_trigger_inputs_i,
  input  wire logic [2:0]        phrase_select_inputs_i,
  input  wire logic              sleep_after_play_ctrl_i,
  input  wire logic              rom_read_select_n_i,
  input  wire logic [7:0]        rom_data_bus_i,
  output logic                   busy_n_o,
  output logic                   internal_busy_n_o,
  output logic                   standby_o,
  output logic                   ceramic_mode_o,
  output logic                   mcu_mode_o,
  output vpc_pkg::vpc_aud_t      audio_out_o,
  output logic [7:0]             sample_o,
  output logic                   sample_valid_o,
  output vpc_pkg::vpc_osc_t      osc_o,
  output logic [22:0]            rom_address_bus_o,
  output logic                   rom_address_bus_oe_o,
  output logic                   rom_strobe_n_o,
  output logic                   rom_strobe_oe_o
);
  import vpc_pkg::*;

  typedef enum logic [2:0] {ST_SLEEP, ST_WAKE, ST_IDLE, ST_FETCH, ST_PLAY, ST_TAIL} vpc_state_t;

  // Next LFSR value, used for stepping
  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    lfsr_step = v[0] ? ((v >> 1) ^ LFSR_TAPS) : (v >> 1);
  endfunction

  vpc_state_t   state_r;
  logic [31:0]  wait_r;
  logic [31:0]  tail_r;
  logic         cap_pend_r;
  logic [3:0]   trig_prev_r;
  logic         rnd_prev_r;
  logic         rnd_mode_r;
  logic [15:0]  lfsr_r;
  logic [6:0]   phrase_r;
  logic         start_r;
  logic         ceramic_r;
  logic         mcu_r;
  logic [22:0]  ptr_r;
  logic         rd_req_r;
  logic         rd_done;
  logic [7:0]   rd_data;
  logic [7:0]   sample_r;
  logic         sample_v_r;
  logic         busy_n_r;
  logic         internal_busy_n_n_r;
  vpc_aud_t     aud_r;
  logic         in_rst;
  logic         rnd_fall;
  logic         trig_chg;
  vpc_rom_t     rom;

  // Pin reset and core reset both initialise the block
  assign in_rst   = sys_rst_i || !reset_n_i;
  assign rnd_fall = rnd_prev_r && !random_play_n_i;
  assign trig_chg = trig_prev_r != phrase_trigger_inputs_i;

  // Strap capture while held in reset
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ceramic_r <= 1'b1;
      mcu_r     <= 1'b0;
    end else if (!reset_n_i) begin
      ceramic_r <= osc_type_select_i;
      mcu_r     <= host_mode_select_i;
    end
  end

  // Input edge history
  always_ff @(posedge core_clk_i) begin
    if (in_rst) begin
      trig_prev_r <= phrase_trigger_inputs_i;           // No false change after reset
      rnd_prev_r  <= 1'b1;
    end else begin
      trig_prev_r <= phrase_trigger_inputs_i;
      rnd_prev_r  <= random_play_n_i;
    end
  end

  // Random address generator runs freely
  always_ff @(posedge core_clk_i) begin
    if (in_rst) begin
      lfsr_r <= LFSR_SEED;
    end else begin
      lfsr_r <= lfsr_step(lfsr_r);
    end
  end

  // Phrase capture delay; a new change restarts the count
  always_ff @(posedge core_clk_i) begin
    if (in_rst) begin
      cap_pend_r <= 1'b0;
      wait_r     <= '0;
      start_r    <= 1'b0;
      phrase_r   <= 7'h00;
      rnd_mode_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (rnd_fall) begin
        rnd_mode_r <= 1'b1;
        phrase_r   <= {lfsr_r[6:4], phrase_select_inputs_i[2:1], lfsr_r[1:0]};
        start_r    <= 1'b1;
        cap_pend_r <= 1'b0;
      end else if (trig_chg) begin
        cap_pend_r <= 1'b1;
        wait_r     <= '0;
      end else if (cap_pend_r) begin
        if (wait_r == CAPTURE_CYCLES - 1) begin
          cap_pend_r <= 1'b0;
          start_r    <= 1'b1;
          rnd_mode_r <= !random_play_n_i;
          phrase_r   <= {phrase_trigger_inputs_i, phrase_select_inputs_i[2:1],
                         (random_play_n_i && !rnd_mode_r) ? phrase_select_inputs_i[0] : 1'b0};
        end else begin
          wait_r <= wait_r + 32'd1;
        end
      end
    end
  end

  // Playback state machine
  always_ff @(posedge core_clk_i) begin
    if (in_rst) begin
      state_r  <= ST_SLEEP;
      tail_r   <= '0;
      ptr_r    <= '0;
      rd_req_r <= 1'b0;
    end else begin
      rd_req_r <= 1'b0;
      case (state_r)
        ST_SLEEP: begin
          tail_r <= '0;
          if (start_r) begin
            state_r <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (tail_r == WAKE_CYC - 1) begin
            state_r <= ST_FETCH;
            tail_r  <= '0;
          end else begin
            tail_r <= tail_r + 32'd1;
          end
        end
        ST_IDLE: begin
          if (start_r) begin
            state_r <= ST_FETCH;
          end else if (!sleep_after_play_ctrl_i) begin
            state_r <= ST_TAIL;
            tail_r  <= '0;
          end
        end
        ST_FETCH: begin
          ptr_r    <= {phrase_r, 16'h0000};
          rd_req_r <= 1'b1;
          state_r  <= ST_PLAY;
        end
        ST_PLAY: begin
          if (rd_done) begin
            if (rd_data == 8'hFF || ptr_r[15:0] == 16'hFFFF) begin
              state_r <= sleep_after_play_ctrl_i ? ST_IDLE : ST_TAIL;
              tail_r  <= '0;
            end else begin
              ptr_r    <= ptr_r + 23'h00_0001;
              rd_req_r <= 1'b1;
            end
          end
        end
        ST_TAIL: begin
          if (start_r) begin
            state_r <= ST_FETCH;
          end else if (sleep_after_play_ctrl_i) begin
            state_r <= ST_IDLE;
          end else if (tail_r == SLEEP_CYCLES - 1) begin
            state_r <= ST_SLEEP;
          end else begin
            tail_r <= tail_r + 32'd1;
          end
        end
        default: state_r <= ST_SLEEP;
      endcase
    end
  end

  // ROM read port
  vpc_rom_port #(
    .AW (ROM_AW),
    .DW (ROM_DW)
  ) u_rom (
    .core_clk_i          (core_clk_i),
    .sys_rst_i           (in_rst),
    .rd_req_i            (rd_req_r),
    .rd_addr_i           (ptr_r),
    .rom_read_select_n_i (rom_read_select_n_i),
    .rom_data_bus_i      (rom_data_bus_i),
    .rd_done_o           (rd_done),
    .rd_data_o           (rd_data),
    .rom_o               (rom)
  );

  // Sample output register
  always_ff @(posedge core_clk_i) begin
    if (in_rst) begin
      sample_r   <= 8'h00;
      sample_v_r <= 1'b0;
    end else begin
      sample_v_r <= rd_done && state_r == ST_PLAY && rd_data != 8'hFF;
      if (rd_done) begin
        sample_r <= rd_data;
      end
    end
  end

  // Status and audio level registers
  always_ff @(posedge core_clk_i) begin
    if (in_rst) begin
      busy_n_r  <= 1'b1;
      internal_busy_n_n_r <= 1'b1;
      aud_r     <= AUD_GND;
    end else begin
      busy_n_r  <= !(state_r == ST_WAKE || state_r == ST_FETCH || state_r == ST_PLAY);
      internal_busy_n_n_r <= !(state_r == ST_FETCH || state_r == ST_PLAY || state_r == ST_IDLE);
      case (state_r)
        ST_SLEEP: aud_r <= AUD_GND;
        ST_PLAY:  aud_r <= AUD_PLAY;
        default:  aud_r <= AUD_HALF;
      endcase
    end
  end

  // Oscillator pins and standby indicator
  always_comb begin
    osc_o.run          = state_r != ST_SLEEP && !in_rst;
    osc_o.pin_two      = osc_o.run;
    osc_o.pin_three    = !osc_o.run && !ceramic_r;
    osc_o.pin_three_oe = !ceramic_r;
  end

  assign standby_o            = !osc_o.run;
  assign busy_n_o             = busy_n_r;
  assign internal_busy_n_o    = internal_busy_n_n_r;
  assign audio_out_o          = aud_r;
  assign ceramic_mode_o       = ceramic_r;
  assign mcu_mode_o           = mcu_r;
  assign sample_o             = sample_r;
  assign sample_valid_o       = sample_v_r;
  assign rom_address_bus_o    = rom.addr;
  assign rom_address_bus_oe_o = rom.addr_oe;
  assign rom_strobe_n_o       = rom.strobe_n;
  assign rom_strobe_oe_o      = rom.strobe_oe;
endmodule // vpc_play_ctrl

//--- bench/vpc_rom_model.sv
// Behavioural external voice ROM on the far side of the read port
`timescale 1ns/1ps
module vpc_rom_model (
  input  wire logic [22:0] addr_i,
  input  wire logic        strobe_n_i,
  input  wire logic        sel_n_i,
  output logic [7:0]       data_o
);
  // Three phrase bytes, then the end marker; garbage while not strobed
  always_comb begin
    if (sel_n_i) begin
      data_o = 8'h00;
    end else if (strobe_n_i) begin
      data_o = 8'hA5 ^ addr_i[7:0];
    end else begin
      data_o = (addr_i[1:0] == 2'd3) ? 8'hFF : {addr_i[20:16], addr_i[2:0]};
    end
  end
endmodule // vpc_rom_model

//--- bench/vpc_play_ctrl_monitor.sv
// Port checker for the playback control block
`timescale 1ns/1ps
module vpc_play_ctrl_monitor
  import vpc_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              sys_rst_i,
  input wire logic              reset_n_i,
  input wire logic              osc_type_select_i,
  input wire logic              host_mode_select_i,
  input wire logic              random_play_n_i,
  input wire logic [3:0]        phrase_trigger_inputs_i,
  input wire logic              rom_read_select_n_i,
  input wire logic              busy_n_o,
  input wire logic              internal_busy_n_o,
  input wire logic              standby_o,
  input wire logic              ceramic_mode_o,
  input wire logic              mcu_mode_o,
  input wire vpc_pkg::vpc_aud_t audio_out_o,
  input wire logic              sample_valid_o,
  input wire vpc_pkg::vpc_osc_t osc_o,
  input wire logic              rom_address_bus_oe_o,
  input wire logic              rom_strobe_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Reset state, pin gating, oscillator pins, straps, capture delay
  property p_rst_state;
    !reset_n_i |=> busy_n_o && internal_busy_n_o && standby_o && audio_out_o == AUD_GND;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
  property p_addr_oe;
    rom_address_bus_oe_o == !rom_read_select_n_i;
  endproperty
  a_addr_oe: assert property (p_addr_oe) else $error("address enable wrong");
  property p_strobe_oe;
    rom_strobe_oe_o == !rom_read_select_n_i;
  endproperty
  a_strobe_oe: assert property (p_strobe_oe) else $error("strobe enable wrong");
  property p_pin_two;
    standby_o |-> !osc_o.pin_two;
  endproperty
  a_pin_two: assert property (p_pin_two) else $error("pin two high in standby");
  property p_pin_three;
    standby_o && !ceramic_mode_o |-> osc_o.pin_three && osc_o.pin_three_oe;
  endproperty
  a_pin_three: assert property (p_pin_three) else $error("pin three not high");
  property p_osc_ind;
    standby_o == !osc_o.run;
  endproperty
  a_osc_ind: assert property (p_osc_ind) else $error("standby vs oscillator");
  property p_strap_osc;
    !reset_n_i |=> ceramic_mode_o == $past(osc_type_select_i);
  endproperty
  a_strap_osc: assert property (p_strap_osc) else $error("osc strap wrong");
  property p_strap_host;
    !reset_n_i |=> mcu_mode_o == $past(host_mode_select_i);
  endproperty
  a_strap_host: assert property (p_strap_host) else $error("host strap wrong");
  property p_capture_hold;
    busy_n_o && random_play_n_i && $changed(phrase_trigger_inputs_i) |=> busy_n_o[*8];
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("early start");
  c_half: cover property (audio_out_o == AUD_HALF);
  c_sample: cover property (sample_valid_o);
  c_rc_sleep_after_play_ctrl: cover property (standby_o && !ceramic_mode_o);
endmodule // vpc_play_ctrl_monitor
bind vpc_play_ctrl vpc_play_ctrl_monitor u_vpc_play_ctrl_monitor (.core_clk_i, .sys_rst_i, .reset_n_i,
  .osc_type_select_i, .host_mode_select_i, .random_play_n_i, .phrase_trigger_inputs_i, .rom_read_select_n_i,
  .busy_n_o, .internal_busy_n_o, .standby_o, .ceramic_mode_o, .mcu_mode_o, .audio_out_o, .sample_valid_o,
  .osc_o, .rom_address_bus_oe_o, .rom_strobe_oe_o);

//--- bench/vpc_play_ctrl_tb.sv
// Testbench for the playback control block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module vpc_play_ctrl_tb;
  import vpc_pkg::*;
  localparam int CAP = 20;
  logic core_clk_i = 0, sys_rst_i = 1, reset_n_i = 1, osc_sel = 1, host_sel = 0, rnd_n = 1;
  logic sleep_ctrl = 1, sel_n = 0;
  logic [3:0] trig = 0;
  logic [2:0] phr = 3'h5;
  logic [7:0] rom_data, sample;
  logic busy_n, internal_busy_n_n, sleep_after_play_ctrl, cer, mcu, svld, addr_oe, strb_n, strb_oe;
  logic [22:0] addr;
  vpc_aud_t aud;
  vpc_osc_t osc;
  int fail_count = 0, check_count = 0, n;
  always #4 core_clk_i = ~core_clk_i;
  vpc_play_ctrl #(.CAPTURE_CYCLES(CAP), .SLEEP_CYCLES(30)) u_vpc_play_ctrl (.core_clk_i, .sys_rst_i, .reset_n_i,
    .osc_type_select_i(osc_sel), .host_mode_select_i(host_sel), .random_play_n_i(rnd_n),
    .phrase_trigger_inputs_i(trig), .phrase_select_inputs_i(phr), .sleep_after_play_ctrl_i(sleep_ctrl),
    .rom_read_select_n_i(sel_n), .rom_data_bus_i(rom_data), .busy_n_o(busy_n), .internal_busy_n_o(internal_busy_n_n),
    .standby_o(sleep_after_play_ctrl), .ceramic_mode_o(cer), .mcu_mode_o(mcu), .audio_out_o(aud), .sample_o(sample),
    .sample_valid_o(svld), .osc_o(osc), .rom_address_bus_o(addr), .rom_address_bus_oe_o(addr_oe),
    .rom_strobe_n_o(strb_n), .rom_strobe_oe_o(strb_oe));
  vpc_rom_model u_vpc_rom_model (.addr_i(addr), .strobe_n_i(strb_n), .sel_n_i(sel_n), .data_o(rom_data));
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait for busy, sample strobe or standby to reach a level
  task automatic wait_sig(input int which, input logic lvl);
    for (n = 0; n < 400; n++) begin
      @(posedge core_clk_i);
      #1;
      if ((which == 0 ? busy_n : which == 1 ? svld : sleep_after_play_ctrl) === lvl) return;
    end
    $display("ERROR %0t: wait %0d timed out", $time, which);
    fail_count++;
    tally_and_finish();
  endtask
  // Pin reset with straps applied
  task automatic pin_reset(input logic ct, input logic hm);
    @(posedge core_clk_i);
    reset_n_i <= 0;
    osc_sel <= ct;
    host_sel <= hm;
    @(posedge core_clk_i);
    #1;
    `CHK({busy_n, sleep_after_play_ctrl, aud}, {2'b11, AUD_GND})
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  // Phrase trigger playback, then hold or sleep tail
  task automatic play(input logic [3:0] t, input logic slp);
    @(posedge core_clk_i);
    sleep_ctrl <= slp;
    trig <= t;
    wait_sig(0, 0);
    `CHK(n >= CAP, 1'b1)
    wait_sig(1, 1);
    `CHK({sample[2:0], sleep_after_play_ctrl, busy_n}, 5'b0)
    wait_sig(0, 1);
    repeat (3) @(posedge core_clk_i);
    #1;
    if (slp) begin
      `CHK({aud, internal_busy_n_n}, {AUD_HALF, 1'b0})
    end else begin
      `CHK(sleep_after_play_ctrl, 1'b0)
      wait_sig(2, 1);
    end
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 0;
    @(posedge core_clk_i);
    #1;
    `CHK({busy_n, internal_busy_n_n, sleep_after_play_ctrl, aud, osc.pin_two}, {3'b111, AUD_GND, 1'b0})
    for (int i = 1; i >= 0; i--) begin
      pin_reset(i[0], i[0]);
      `CHK({cer, mcu}, {i[0], i[0]})
      if (i == 0) `CHK(osc.pin_three, 1'b1)
    end
    play(4'h3, 1);
    play(4'hC, 0);
    @(posedge core_clk_i);
    sel_n <= 1;
    repeat (4) @(posedge core_clk_i);
    #1;
    `CHK({addr_oe, strb_oe}, 2'b00)
    @(posedge core_clk_i);
    sel_n <= 0;
    rnd_n <= 0;
    @(posedge core_clk_i);
    rnd_n <= 1;
    wait_sig(0, 0);
    `CHK(busy_n, 1'b0)
    pin_reset(1, 0);
    tally_and_finish();
  end
endmodule // vpc_play_ctrl_tb
